// *** rtl/pieb_pkg.sv ***
// Purpose: Constants for the peripheral interrupt enable bank.
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register.
// Notes:   8-bit registers sit in the low byte, upper bits read as zero.
// How it works
// [R1] The pin change summary flag is read only and writes never alter it.
// [R2] The summary flag clears itself only once every per-pin change flag has been cleared.
// [R3] Each peripheral flag sets on its event whatever its enable bit or the global gate hold.
// [R4] Software should clear stale flags before it sets the matching enable bit.
// [R5] No peripheral interrupt reaches the core unless the peripheral group gate is also set.
// [R6] Enable bit 3 of the first register passes the sync port interrupt when one, blocks it when zero.
// [R7] All enable bits are read/write, clear on every reset, and pass their flag only when one.
package pieb_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_EN_A   = 8'h00;
  localparam logic [7:0] OFF_EN_B   = 8'h04;
  localparam logic [7:0] OFF_CTRL   = 8'h08;
  localparam logic [7:0] OFF_FLAG_A = 8'h0c;
  localparam logic [7:0] OFF_FLAG_B = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Reset values
  localparam logic [7:0] EN_RST   = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;

  // Field positions
  localparam int unsigned BIT_GLOBAL_GATE = 7;
  localparam int unsigned BIT_GROUP_GATE  = 6;
  localparam int unsigned BIT_SUMMARY     = 0;
  localparam int unsigned BIT_SYNC_PORT   = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/pieb_top.sv ***
// Purpose: Peripheral interrupt enable bank with flags, gates and summary flag.
// Assumes: Event and pin change inputs come from logic on ref_clk_i.
// Notes:   Flags clear by writing one; a new event in the same cycle wins.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module pieb_top #(
  parameter int unsigned N_PINS = 8
) (
  // Clock, reset, enable
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  // AXI4-Lite write address
  input  wire logic                         s_axi_awvalid_i,
  output logic                              s_axi_awready_o,
  input  wire logic [pieb_pkg::ADDR_W-1:0]  s_axi_awaddr_i,
  input  wire logic [2:0]                   s_axi_awprot_i,
  // AXI4-Lite write data
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  input  wire logic [pieb_pkg::DATA_W-1:0]  s_axi_wdata_i,
  input  wire logic [3:0]                   s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic                              s_axi_bvalid_o,
  input  wire logic                         s_axi_bready_i,
  output logic [1:0]                        s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire logic                         s_axi_arvalid_i,
  output logic                              s_axi_arready_o,
  input  wire logic [pieb_pkg::ADDR_W-1:0]  s_axi_araddr_i,
  input  wire logic [2:0]                   s_axi_arprot_i,
  // AXI4-Lite read data
  output logic                              s_axi_rvalid_o,
  input  wire logic                         s_axi_rready_i,
  output logic [pieb_pkg::DATA_W-1:0]       s_axi_rdata_o,
  output logic [1:0]                        s_axi_rresp_o,
  // Peripheral events and pin change flags
  input  wire logic [pieb_pkg::REG_W-1:0]   evt_a_i,
  input  wire logic [pieb_pkg::REG_W-1:0]   evt_b_i,
  input  wire logic [N_PINS-1:0]            per_pin_change_flag_regs_i,
  // To the core
  output logic                              periph_irq_o,
  output logic                              pin_change_summary_flag_o
);

  // Refused at elaboration: the summary OR and the status word serve 1 to 32 pins
  if (N_PINS < 1 || N_PINS > 32) begin
    $error("N_PINS must lie in 1..32");
  end

  // Bus state
  logic                         awready_r,  awready_nxt;
  logic                         aw_held_r,  aw_held_nxt;
  logic [pieb_pkg::ADDR_W-1:0]  aw_addr_r,  aw_addr_nxt;
  logic                         wready_r,   wready_nxt;
  logic                         w_held_r,   w_held_nxt;
  logic [pieb_pkg::DATA_W-1:0]  w_data_r,   w_data_nxt;
  logic [3:0]                   w_strb_r,   w_strb_nxt;
  logic                         bvalid_r,   bvalid_nxt;
  logic [1:0]                   bresp_r,    bresp_nxt;
  logic                         arready_r,  arready_nxt;
  logic                         rvalid_r,   rvalid_nxt;
  logic [pieb_pkg::DATA_W-1:0]  rdata_r,    rdata_nxt;
  logic [1:0]                   rresp_r,    rresp_nxt;
  // Block state
  logic [pieb_pkg::REG_W-1:0]   en_a_r,     en_a_nxt;
  logic [pieb_pkg::REG_W-1:0]   en_b_r,     en_b_nxt;
  logic [pieb_pkg::REG_W-1:0]   ctrl_r,     ctrl_nxt;
  logic [pieb_pkg::REG_W-1:0]   flag_a_r,   flag_a_nxt;
  logic [pieb_pkg::REG_W-1:0]   flag_b_r,   flag_b_nxt;
  logic                         summary_r,  summary_nxt;
  logic                         irq_r,      irq_nxt;
  // Decode helpers
  logic                         aw_take;
  logic                         w_take;
  logic                         ar_take;
  logic                         do_wr;
  logic                         lane0;
  logic [7:0]                   wr_off;
  logic [7:0]                   rd_off;
  logic [pieb_pkg::REG_W-1:0]   clr_a;
  logic [pieb_pkg::REG_W-1:0]   clr_b;

  // Bus handshakes; address and data are taken in either order, one write at a time
  always_comb begin
    aw_take     = s_axi_awvalid_i & awready_r;
    w_take      = s_axi_wvalid_i & wready_r;
    ar_take     = s_axi_arvalid_i & arready_r;
    aw_addr_nxt = aw_take ? s_axi_awaddr_i : aw_addr_r;
    w_data_nxt  = w_take ? s_axi_wdata_i : w_data_r;
    w_strb_nxt  = w_take ? s_axi_wstrb_i : w_strb_r;
    do_wr       = (aw_held_r | aw_take) & (w_held_r | w_take);
    aw_held_nxt = (aw_held_r | aw_take) & ~do_wr;
    w_held_nxt  = (w_held_r | w_take) & ~do_wr;
    bvalid_nxt  = (bvalid_r & ~s_axi_bready_i) | do_wr;
    awready_nxt = ~aw_held_nxt & ~bvalid_nxt & ~do_wr;
    wready_nxt  = ~w_held_nxt & ~bvalid_nxt & ~do_wr;
    wr_off      = 8'(aw_addr_nxt & ~pieb_pkg::ADDR_W'(3));
    rd_off      = 8'(s_axi_araddr_i & ~pieb_pkg::ADDR_W'(3));
    lane0       = w_strb_nxt[0];
    bresp_nxt   = bresp_r;
    if (do_wr) begin
      case (wr_off)
        pieb_pkg::OFF_EN_A, pieb_pkg::OFF_EN_B, pieb_pkg::OFF_CTRL,
        pieb_pkg::OFF_FLAG_A, pieb_pkg::OFF_FLAG_B, pieb_pkg::OFF_STATUS: begin
          bresp_nxt = pieb_pkg::RESP_OKAY;
        end
        default: begin
          bresp_nxt = pieb_pkg::RESP_SLVERR;
        end
      endcase
    end
    rvalid_nxt  = (rvalid_r & ~s_axi_rready_i) | ar_take;
    arready_nxt = ~rvalid_nxt;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (ar_take) begin
      rresp_nxt = pieb_pkg::RESP_OKAY;
      case (rd_off)
        pieb_pkg::OFF_EN_A:   rdata_nxt = 32'(en_a_r);
        pieb_pkg::OFF_EN_B:   rdata_nxt = 32'(en_b_r);
        pieb_pkg::OFF_CTRL:   rdata_nxt = 32'(ctrl_r);
        pieb_pkg::OFF_FLAG_A: rdata_nxt = 32'(flag_a_r);
        pieb_pkg::OFF_FLAG_B: rdata_nxt = 32'(flag_b_r);
        pieb_pkg::OFF_STATUS: rdata_nxt = 32'(summary_r) << pieb_pkg::BIT_SUMMARY;
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = pieb_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      awready_r <= 1'b1;
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      wready_r  <= 1'b1;
      w_held_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= pieb_pkg::RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= pieb_pkg::RESP_OKAY;
    end else if (ce_i) begin
      awready_r <= awready_nxt;
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      wready_r  <= wready_nxt;
      w_held_r  <= w_held_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // Enables, gates, flags and the interrupt line
  always_comb begin
    en_a_nxt = en_a_r;
    en_b_nxt = en_b_r;
    ctrl_nxt = ctrl_r;
    clr_a    = '0;
    clr_b    = '0;
    if (do_wr && lane0) begin
      case (wr_off)
        pieb_pkg::OFF_EN_A:   en_a_nxt = w_data_nxt[pieb_pkg::REG_W-1:0]; // see [R7]
        pieb_pkg::OFF_EN_B:   en_b_nxt = w_data_nxt[pieb_pkg::REG_W-1:0]; // see [R7]
        pieb_pkg::OFF_CTRL:   ctrl_nxt = w_data_nxt[pieb_pkg::REG_W-1:0];
        pieb_pkg::OFF_FLAG_A: clr_a    = w_data_nxt[pieb_pkg::REG_W-1:0];
        pieb_pkg::OFF_FLAG_B: clr_b    = w_data_nxt[pieb_pkg::REG_W-1:0];
        default: begin
          // Status writes land here and change nothing
          clr_a = '0; // see [R1]
        end
      endcase
    end
    // A new event outranks a clear in the same cycle, and enables do not matter
    flag_a_nxt  = (flag_a_r & ~clr_a) | evt_a_i; // see [R3]
    flag_b_nxt  = (flag_b_r & ~clr_b) | evt_b_i; // see [R3]
    // Summary follows the per-pin flags only, so it drops only when all are clear
    summary_nxt = |per_pin_change_flag_regs_i; // see [R1] [R2]
    // Bit 3 of the first enable gates the sync port like every other source
    irq_nxt = ctrl_r[pieb_pkg::BIT_GLOBAL_GATE] & ctrl_r[pieb_pkg::BIT_GROUP_GATE] // see [R5]
              & |{flag_a_r & en_a_r, flag_b_r & en_b_r}; // see [R6] [R7]
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      en_a_r    <= pieb_pkg::EN_RST; // see [R7]
      en_b_r    <= pieb_pkg::EN_RST; // see [R7]
      ctrl_r    <= pieb_pkg::CTRL_RST;
      flag_a_r  <= pieb_pkg::FLAG_RST;
      flag_b_r  <= pieb_pkg::FLAG_RST;
      summary_r <= 1'b0;
      irq_r     <= 1'b0;
    end else if (ce_i) begin
      en_a_r    <= en_a_nxt;
      en_b_r    <= en_b_nxt;
      ctrl_r    <= ctrl_nxt;
      flag_a_r  <= flag_a_nxt;
      flag_b_r  <= flag_b_nxt;
      summary_r <= summary_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign s_axi_awready_o           = awready_r;
  assign s_axi_wready_o            = wready_r;
  assign s_axi_bvalid_o            = bvalid_r;
  assign s_axi_bresp_o             = bresp_r;
  assign s_axi_arready_o           = arready_r;
  assign s_axi_rvalid_o            = rvalid_r;
  assign s_axi_rdata_o             = rdata_r;
  assign s_axi_rresp_o             = rresp_r;
  assign periph_irq_o              = irq_r;
  assign pin_change_summary_flag_o = summary_r;

  // Checks
  sequence s_write_done;
    ce_i && do_wr;
  endsequence

  sequence s_resp_up;
    bvalid_r;
  endsequence

  property p_write_resp;
    @(posedge ref_clk_i) disable iff (rst_i)
      s_write_done |=> s_resp_up;
  endproperty

  chk_write_resp_due: assert property (p_write_resp)
    else $error("write response missing after write");

  sequence s_read_taken;
    ce_i && ar_take;
  endsequence

  sequence s_read_up;
    rvalid_r;
  endsequence

  property p_read_resp;
    @(posedge ref_clk_i) disable iff (rst_i)
      s_read_taken |=> s_read_up;
  endproperty

  chk_read_resp_due: assert property (p_read_resp)
    else $error("read response missing after address");

  chk_enable_a_write: assert property ( // see [R7]
    @(posedge ref_clk_i) disable iff (rst_i)
      ce_i && do_wr && lane0 && wr_off == pieb_pkg::OFF_EN_A
      |=> en_a_r == $past(w_data_nxt[pieb_pkg::REG_W-1:0]))
    else $error("enable write did not land");

  chk_global_gate_blocks: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      ce_i && !ctrl_r[pieb_pkg::BIT_GLOBAL_GATE] |=> !irq_r)
    else $error("interrupt passed with global gate clear");

  chk_summary_held_high: assert property ( // see [R1]
    @(posedge ref_clk_i) disable iff (rst_i)
      ce_i && (|per_pin_change_flag_regs_i) && do_wr && wr_off == pieb_pkg::OFF_STATUS |=> summary_r)
    else $error("summary flag changed by a write");

  chk_summary_clears_late: assert property ( // see [R2]
    @(posedge ref_clk_i) disable iff (rst_i)
      ce_i && summary_r && (|per_pin_change_flag_regs_i) |=> summary_r)
    else $error("summary flag cleared while a pin flag stands");

  chk_flag_sets_always: assert property ( // see [R3]
    @(posedge ref_clk_i) disable iff (rst_i)
      ce_i && (evt_a_i != 8'h00) |=> ((flag_a_r & $past(evt_a_i)) == $past(evt_a_i)))
    else $error("event did not set its flag");

  chk_flag_b_sets: assert property ( // see [R3]
    @(posedge ref_clk_i) disable iff (rst_i)
      ce_i && (evt_b_i != 8'h00) |=> ((flag_b_r & $past(evt_b_i)) == $past(evt_b_i)))
    else $error("event did not set its second bank flag");

  chk_group_gate_blocks: assert property ( // see [R5]
    @(posedge ref_clk_i) disable iff (rst_i)
      ce_i && !ctrl_r[pieb_pkg::BIT_GROUP_GATE] |=> !irq_r)
    else $error("interrupt passed with group gate clear");

  chk_sync_port_pass: assert property ( // see [R6]
    @(posedge ref_clk_i) disable iff (rst_i)
      ce_i && flag_a_r[pieb_pkg::BIT_SYNC_PORT] && en_a_r[pieb_pkg::BIT_SYNC_PORT]
      && ctrl_r[pieb_pkg::BIT_GLOBAL_GATE] && ctrl_r[pieb_pkg::BIT_GROUP_GATE] |=> irq_r)
    else $error("sync port interrupt did not pass");

  chk_enables_block: assert property ( // see [R7]
    @(posedge ref_clk_i) disable iff (rst_i)
      ce_i && en_a_r == 8'h00 && en_b_r == 8'h00 |=> !irq_r)
    else $error("interrupt passed with all enables clear");

  chk_enable_reset: assert property ( // see [R7]
    @(posedge ref_clk_i) disable iff (rst_i)
      $fell(rst_i) |-> (en_a_r == 8'h00 && en_b_r == 8'h00))
    else $error("enables not clear after reset");

endmodule

// *** bench/pieb_src_model.sv ***
// Purpose: Model of the peripherals and pin change flags feeding the bank.
// Assumes: Commands come from the bench on ref_clk_i.
// Notes:   Events are one-cycle pulses; pin flags hold until software clears them.
`timescale 1ns/1ns
module pieb_src_model (
  // Clock and commands
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] fire_a_i,
  input  wire logic [7:0] fire_b_i,
  input  wire logic [7:0] pin_set_i,
  input  wire logic [7:0] pin_clr_i,
  // Toward the bank
  output logic      [7:0] evt_a_o,
  output logic      [7:0] evt_b_o,
  output logic      [7:0] pins_o
);
  initial begin
    evt_a_o = 8'h00;
    evt_b_o = 8'h00;
    pins_o  = 8'h00;
  end
  always @(posedge ref_clk_i) begin
    evt_a_o <= fire_a_i;
    evt_b_o <= fire_b_i;
    // Each flag clears on its own pin_clr_i bit, so the summary sees partial clears
    pins_o  <= (pins_o | pin_set_i) & ~pin_clr_i;
  end
endmodule

// *** bench/pieb_top_tb_top.sv ***
// Purpose: Self-checking bench for the peripheral interrupt enable bank.
// Assumes: AXI4-Lite master drives by non-blocking assignment after each edge.
// Notes:   Outputs are sampled at the edge, before that edge's updates land.
`timescale 1ns/1ns
module pieb_top_tb_top;
  // Bus master drive
  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic        awv        = 1'b0;
  logic        wv         = 1'b0;
  logic        br         = 1'b0;
  logic        arv        = 1'b0;
  logic        rr         = 1'b0;
  logic [7:0]  aw         = 8'h00;
  logic [7:0]  ar         = 8'h00;
  logic [31:0] wd         = 32'h0000_0000;
  // Source model commands
  logic [7:0]  fa         = 8'h00;
  logic [7:0]  fb         = 8'h00;
  logic [7:0]  ps         = 8'h00;
  logic [7:0]  pc         = 8'h00;
  // Answers taken by the master
  logic [31:0] rd;
  logic [1:0]  rs;
  logic [1:0]  bs;
  // Design and model outputs
  logic        awrdy;
  logic        wrdy;
  logic        bv;
  logic        arrdy;
  logic        rv;
  logic        irq;
  logic        summ;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdat;
  logic [7:0]  ea;
  logic [7:0]  eb;
  logic [7:0]  pins;
  // Counters
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  pieb_src_model i_pieb_src_model (.ref_clk_i(clk), .fire_a_i(fa), .fire_b_i(fb), .pin_set_i(ps),
    .pin_clr_i(pc), .evt_a_o(ea), .evt_b_o(eb), .pins_o(pins));
  pieb_top #(.N_PINS(8)) i_pieb_top (.ref_clk_i(clk), .rst_i(rst), .ce_i(1'b1),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_awaddr_i(aw), .s_axi_awprot_i(3'h0),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy), .s_axi_araddr_i(ar), .s_axi_arprot_i(3'h0),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
    .evt_a_i(ea), .evt_b_i(eb), .per_pin_change_flag_regs_i(pins),
    .periph_irq_o(irq), .pin_change_summary_flag_o(summ));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Whole run needs well under a thousand cycles, so this only trips on a hang
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awv <= 1'b1;
    wv  <= 1'b1;
    aw  <= a;
    wd  <= d;
    br  <= 1'b1;
    do begin
      @(posedge clk);
      if (awrdy) begin
        awv <= 1'b0;
      end
      if (wrdy) begin
        wv <= 1'b0;
      end
    end while (bv !== 1'b1);
    bs = bresp;
    br <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    arv <= 1'b1;
    ar  <= a;
    rr  <= 1'b1;
    do begin
      @(posedge clk);
      if (arrdy) begin
        arv <= 1'b0;
      end
    end while (rv !== 1'b1);
    rd = rdat;
    rs = rresp;
    rr <= 1'b0;
  endtask
  // Every mapped word reads zero with an OKAY answer
  task automatic chk_all_clear();
    logic [7:0] offs [6] = '{pieb_pkg::OFF_EN_A, pieb_pkg::OFF_EN_B, pieb_pkg::OFF_CTRL,
                             pieb_pkg::OFF_FLAG_A, pieb_pkg::OFF_FLAG_B, pieb_pkg::OFF_STATUS};
    foreach (offs[i]) begin
      rdr(offs[i]);
      chk(rd, 32'h0000_0000);
      chk({30'h0, rs}, {30'h0, pieb_pkg::RESP_OKAY});
    end
  endtask
  task automatic t_reset();
    chk_all_clear();
    rdr(8'h18);
    chk({30'h0, rs}, {30'h0, pieb_pkg::RESP_SLVERR});
    chk(rd, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_rw();
    wr(pieb_pkg::OFF_EN_A, 32'hffff_ffa5);
    chk({30'h0, bs}, {30'h0, pieb_pkg::RESP_OKAY});
    rdr(pieb_pkg::OFF_EN_A);
    chk(rd, 32'h0000_00a5);
    wr(pieb_pkg::OFF_EN_B, 32'h0000_005a);
    rdr(pieb_pkg::OFF_EN_B);
    chk(rd, 32'h0000_005a);
    // An unmapped word is refused and leaves the map alone
    wr(8'h18, 32'h0000_00ff);
    chk({30'h0, bs}, {30'h0, pieb_pkg::RESP_SLVERR});
    rdr(pieb_pkg::OFF_EN_B);
    chk(rd, 32'h0000_005a);
    wr(pieb_pkg::OFF_EN_A, 32'h0000_0000);
    wr(pieb_pkg::OFF_EN_B, 32'h0000_0000);
    $display("test rw done");
  endtask
  task automatic t_flags();
    @(posedge clk);
    fa <= 8'hff;
    fb <= 8'hff;
    @(posedge clk);
    fa <= 8'h00;
    fb <= 8'h00;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    rdr(pieb_pkg::OFF_FLAG_A);
    chk(rd, 32'h0000_00ff);
    rdr(pieb_pkg::OFF_FLAG_B);
    chk(rd, 32'h0000_00ff);
    // Clear stale flags before any enable goes up
    wr(pieb_pkg::OFF_FLAG_A, 32'h0000_00ff);
    wr(pieb_pkg::OFF_FLAG_B, 32'h0000_00ff);
    rdr(pieb_pkg::OFF_FLAG_A);
    chk(rd, 32'h0000_0000);
    rdr(pieb_pkg::OFF_FLAG_B);
    chk(rd, 32'h0000_0000);
    $display("test flags done");
  endtask
  task automatic t_gate();
    wr(pieb_pkg::OFF_EN_A, 32'h0000_0008);
    wr(pieb_pkg::OFF_CTRL, 32'h0000_0080);
    @(posedge clk);
    fa <= 8'h08;
    @(posedge clk);
    fa <= 8'h00;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(pieb_pkg::OFF_CTRL, 32'h0000_00c0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(pieb_pkg::OFF_EN_A, 32'h0000_00f7);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(pieb_pkg::OFF_EN_A, 32'h0000_0000);
    wr(pieb_pkg::OFF_FLAG_A, 32'h0000_00ff);
    $display("test gate done");
  endtask
  task automatic t_summary();
    @(posedge clk);
    ps <= 8'h81;
    @(posedge clk);
    ps <= 8'h00;
    repeat (3) @(posedge clk);
    chk({31'h0, summ}, 32'h0000_0001);
    wr(pieb_pkg::OFF_STATUS, 32'h0000_0000);
    chk({30'h0, bs}, {30'h0, pieb_pkg::RESP_OKAY});
    rdr(pieb_pkg::OFF_STATUS);
    chk(rd, 32'h0000_0001);
    @(posedge clk);
    pc <= 8'h80;
    @(posedge clk);
    pc <= 8'h00;
    repeat (3) @(posedge clk);
    chk({31'h0, summ}, 32'h0000_0001);
    @(posedge clk);
    pc <= 8'h01;
    @(posedge clk);
    pc <= 8'h00;
    repeat (3) @(posedge clk);
    chk({31'h0, summ}, 32'h0000_0000);
    $display("test summary done");
  endtask
  // A reset in mid-run clears enables that software had set
  task automatic t_reset_mid();
    wr(pieb_pkg::OFF_EN_A, 32'h0000_00ff);
    wr(pieb_pkg::OFF_EN_B, 32'h0000_00ff);
    rdr(pieb_pkg::OFF_EN_A);
    chk(rd, 32'h0000_00ff);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_all_clear();
    $display("test reset_mid done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_flags();
    t_gate();
    t_summary();
    t_reset_mid();
    end_of_test();
  end
endmodule
